// *** hw/ms_tick.sv ***
// free-running millisecond tick from the system clock
`timescale 1ns/1ns
`default_nettype none

module ms_tick #(
	parameter int TICK_CYCLES = 125000
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);

	sf_sup_pkg::tick_t st;
	sf_sup_pkg::tick_t next_st;

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (st.cnt == 17'(TICK_CYCLES - 1)) begin
			next_st.cnt  = 17'h00000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 17'h00001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule

`default_nettype wire

// *** hw/pin_sync.sv ***
// three-stage synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);

	sf_sup_pkg::sync_t st;
	sf_sup_pkg::sync_t next_st;

	always_comb begin
		next_st    = st;
		next_st.ff = {st.ff[1:0], din};
		if (st.ff[1] == st.ff[2]) begin
			next_st.q = st.ff[2];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.q;

endmodule

`default_nettype wire

// *** hw/sf_supervision_loopback_ctrl.sv ***
// supervisory path-cut, receive notch and facility loopback controller
//
// Behaviour
// - distant seizure: keep transmit cut 625 ms after receive tone stops
// - distant seizure: remove receive notch filter 50 ms after tone stops
// - lead ground to battery: keep transmit cut 125 ms
// - lead battery to ground: precut at once, hold cut 625 ms
// - incoming dial pulse: cut transmit path within 7 ms of first pulse
// - incoming dialing: hold cut until 625 ms after last tone-off
// - incoming dialing: notch in 13 ms after first pulse, out at later of 50/225 ms
// - distant disconnect: insert notch 13 ms after tone returns
// - local disconnect: cut continuously, notch inserted, back to idle
// - manual loopback follows the manual loop switch
// - manual mode ignores the loopback tone
// - two-tone: arm after 1.4 s of tone, loop when tone goes
// - in two-tone loopback, 0.7 s of tone ends loopback at once
// - two-tone loopback timeout of none, 2.6 or 20.8 minutes
// - busy-out grounds E lead in loopback, only A-side and Type I
// - transmit cut within 5 ms of any local lead change
`timescale 1ns/1ns
`default_nettype none

`include "sf_sup_regs.svh"

module sf_supervision_loopback_ctrl #(
	parameter int TICK_CYCLES  = `TICK_CYCLES,
	parameter int TO_SHORT_MS  = `TO_SHORT_DMIN * `MS_PER_DMIN,
	parameter int TO_LONG_MS   = `TO_LONG_DMIN * `MS_PER_DMIN
) (
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST,
	input  wire logic                 RCV_TONE,
	input  wire logic                 LOOP_TONE,
	input  wire logic                 SIG_LEAD_BUSY,
	input  wire logic                 MANUAL_LOOP_SWITCH,
	input  wire logic [`ADDR_W-1:0]   ADDR,
	input  wire logic [`DATA_W-1:0]   WR_DATA,
	input  wire logic                 WR_EN,
	input  wire logic                 RD_EN,
	output logic      [`DATA_W-1:0]   RD_DATA,
	output logic                      XMT_CUT,
	output logic                      RECEIVE_NOTCH_FILTER,
	output logic                      LOOPBACK,
	output logic                      E_LEAD_GND
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		sf_sup_pkg::ctrl_t          ctrl;
		sf_sup_pkg::pins_t          prev;
		sf_sup_pkg::call_t          call;
		sf_sup_pkg::loop_t          loop;
		logic                       cut;
		logic                       notch;
		logic                       loop_act;
		logic                       e_gnd;
		logic                       ins_pend;
		logic                       rem_pend;
		logic [`TIMER_W-1:0]        cut_tmr;
		logic [`TIMER_W-1:0]        ins_tmr;
		logic [`TIMER_W-1:0]        rem_tmr;
		logic [`TIMER_W-1:0]        hold_tmr;
		logic [`TONE_W-1:0]         tone_cnt;
		logic [`LONG_W-1:0]         to_cnt;
		logic [`DATA_W-1:0]         rd_data;
	} state_t;

	state_t                st;
	state_t                next_st;
	sf_sup_pkg::pins_t     pins;
	logic [3:0]            pins_raw;
	logic                  tick;

	// ----------------------------------------
	// pin synchronisers and timebase
	// ----------------------------------------
	assign pins_raw = {LOOP_TONE, SIG_LEAD_BUSY, MANUAL_LOOP_SWITCH, RCV_TONE};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			pin_sync u_sync (
				.clk  (SYS_CLK),
				.rst  (RST),
				.din  (pins_raw[gi]),
				.dout (pins[gi])
			);
		end
	endgenerate

	ms_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk  (SYS_CLK),
		.rst  (RST),
		.tick (tick)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [`TIMER_W-1:0] dec(input logic [`TIMER_W-1:0] t, input logic en);
		dec = (en && t != '0) ? t - `TIMER_W'(1) : t;
	endfunction

	function automatic logic [`LONG_W-1:0] to_limit(input sf_sup_pkg::timeout_t sel);
		unique case (sel)
			sf_sup_pkg::TO_SHORT: to_limit = `LONG_W'(TO_SHORT_MS);
			sf_sup_pkg::TO_LONG:  to_limit = `LONG_W'(TO_LONG_MS);
			default:              to_limit = '0;
		endcase
	endfunction

	logic rcv_rise;
	logic rcv_fall;
	logic lead_rise;
	logic lead_fall;

	assign rcv_rise  = pins.rcv_tone & ~st.prev.rcv_tone;
	assign rcv_fall  = ~pins.rcv_tone & st.prev.rcv_tone;
	assign lead_rise = pins.sig_busy & ~st.prev.sig_busy;
	assign lead_fall = ~pins.sig_busy & st.prev.sig_busy;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st      = st;
		next_st.prev = pins;

		// interval timers, all on the common tick
		next_st.cut_tmr  = dec(st.cut_tmr, tick);
		next_st.ins_tmr  = dec(st.ins_tmr, tick);
		next_st.rem_tmr  = dec(st.rem_tmr, tick);
		next_st.hold_tmr = dec(st.hold_tmr, tick);

		// local lead changes
		if (lead_rise) begin
			next_st.cut_tmr = `TIMER_W'(`LOCAL_CUT_MS);
		end else if (lead_fall) begin
			next_st.cut_tmr = `TIMER_W'(`CUT_HOLD_MS);
		end

		// received tone changes
		if (rcv_fall) begin
			next_st.cut_tmr  = `TIMER_W'(`CUT_HOLD_MS);
			next_st.rem_tmr  = `TIMER_W'(`NOTCH_REM_MS);
			next_st.rem_pend = 1'b1;
			next_st.ins_pend = 1'b0;
		end else if (rcv_rise) begin
			next_st.rem_pend = 1'b0;
			if (st.call == sf_sup_pkg::CALL_BUSY) begin
				next_st.cut_tmr = `TIMER_W'(`CUT_HOLD_MS);
			end
			if (!st.notch && !st.ins_pend) begin
				next_st.ins_tmr  = `TIMER_W'(`NOTCH_INS_MS);
				next_st.hold_tmr = `TIMER_W'(`NOTCH_MIN_MS);
				next_st.ins_pend = 1'b1;
			end
		end

		// notch filter moves when its interval runs out
		if (next_st.ins_pend && next_st.ins_tmr == '0) begin
			next_st.notch    = 1'b1;
			next_st.ins_pend = 1'b0;
		end
		if (next_st.rem_pend && next_st.rem_tmr == '0 && next_st.hold_tmr == '0) begin
			next_st.notch    = 1'b0;
			next_st.rem_pend = 1'b0;
		end

		// call supervision
		unique case (st.call)
			sf_sup_pkg::CALL_IDLE: begin
				if (rcv_fall || lead_rise) begin
					next_st.call = sf_sup_pkg::CALL_BUSY;
				end
			end
			sf_sup_pkg::CALL_BUSY: begin
				if (!pins.sig_busy && pins.rcv_tone && next_st.cut_tmr == '0) begin
					next_st.call = sf_sup_pkg::CALL_IDLE;
				end
			end
		endcase
		if (next_st.call == sf_sup_pkg::CALL_IDLE) begin
			next_st.notch    = 1'b1;
			next_st.ins_pend = 1'b0;
			next_st.rem_pend = 1'b0;
		end
		next_st.cut = (next_st.call == sf_sup_pkg::CALL_IDLE) || (next_st.cut_tmr != '0);

		// loopback tone duration, restarted on every drop
		if (!pins.loop_tone) begin
			next_st.tone_cnt = '0;
		end else if (tick && st.tone_cnt != '1) begin
			next_st.tone_cnt = st.tone_cnt + `TONE_W'(1);
		end

		// loopback control
		if (!st.ctrl.two_tone) begin
			next_st.loop   = pins.manual_loop_switch ? sf_sup_pkg::LOOP_ON
			                                         : sf_sup_pkg::LOOP_OFF;
			next_st.to_cnt = '0;
		end else begin
			unique case (st.loop)
				sf_sup_pkg::LOOP_OFF: begin
					if (st.tone_cnt >= `TONE_W'(`ARM_TONE_MS)) begin
						next_st.loop = sf_sup_pkg::LOOP_ARMED;
					end
				end
				sf_sup_pkg::LOOP_ARMED: begin
					if (!pins.loop_tone) begin
						next_st.loop   = sf_sup_pkg::LOOP_ON;
						next_st.to_cnt = '0;
					end
				end
				sf_sup_pkg::LOOP_ON: begin
					if (tick) begin
						next_st.to_cnt = st.to_cnt + `LONG_W'(1);
					end
					if (st.tone_cnt >= `TONE_W'(`DISARM_TONE_MS)) begin
						next_st.loop     = sf_sup_pkg::LOOP_OFF;
						next_st.tone_cnt = '0;
					end else if (to_limit(st.ctrl.timeout) != '0 &&
					             st.to_cnt >= to_limit(st.ctrl.timeout)) begin
						next_st.loop = sf_sup_pkg::LOOP_OFF;
					end
				end
				default: begin
					next_st.loop = sf_sup_pkg::LOOP_OFF;
				end
			endcase
		end
		next_st.loop_act = (next_st.loop == sf_sup_pkg::LOOP_ON);
		next_st.e_gnd    = next_st.loop_act && st.ctrl.busy_out &&
		                   st.ctrl.a_side && st.ctrl.type_one;

		// register port
		if (WR_EN && ADDR == `CTRL_OFS) begin
			next_st.ctrl = sf_sup_pkg::ctrl_t'(WR_DATA[`CTRL_W-1:0]);
		end
		next_st.rd_data = '0;
		if (RD_EN) begin
			unique case (ADDR)
				`CTRL_OFS:   next_st.rd_data = {{(`DATA_W-`CTRL_W){1'b0}}, st.ctrl};
				`STATUS_OFS: next_st.rd_data = {{(`DATA_W-`STATUS_W){1'b0}}, st.e_gnd,
				                                st.call == sf_sup_pkg::CALL_BUSY,
				                                st.loop == sf_sup_pkg::LOOP_ARMED,
				                                st.loop_act, st.notch, st.cut};
				default:     next_st.rd_data = '0;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st       <= '0;
			st.call  <= sf_sup_pkg::CALL_IDLE;
			st.loop  <= sf_sup_pkg::LOOP_OFF;
			st.cut   <= 1'b1;
			st.notch <= 1'b1;
			st.ctrl  <= sf_sup_pkg::ctrl_t'(`CTRL_RESET);
		end else begin
			st <= next_st;
		end
	end

	assign RD_DATA              = st.rd_data;
	assign XMT_CUT              = st.cut;
	assign RECEIVE_NOTCH_FILTER = st.notch;
	assign LOOPBACK             = st.loop_act;
	assign E_LEAD_GND           = st.e_gnd;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	sequence s_seize;
		st.call == sf_sup_pkg::CALL_IDLE && rcv_fall;
	endsequence

	sequence s_pulse_in_call;
		st.call == sf_sup_pkg::CALL_BUSY && rcv_rise && !lead_rise && !lead_fall;
	endsequence

	sequence s_first_pulse;
		rcv_rise && !st.notch && !st.ins_pend;
	endsequence

	property p_seize_cut;
		s_seize |=> XMT_CUT && st.cut_tmr == `TIMER_W'(`CUT_HOLD_MS);
	endproperty
	a_seize_cut: assert property (p_seize_cut) else $error("seizure cut hold wrong");

	property p_seize_notch;
		s_seize |=> st.rem_pend && st.rem_tmr == `TIMER_W'(`NOTCH_REM_MS) && RECEIVE_NOTCH_FILTER;
	endproperty
	a_seize_notch: assert property (p_seize_notch) else $error("notch removal not started");

	property p_lead_busy_cut;
		lead_rise && !rcv_fall && !rcv_rise |=>
			XMT_CUT && st.cut_tmr == `TIMER_W'(`LOCAL_CUT_MS);
	endproperty
	a_lead_busy_cut: assert property (p_lead_busy_cut) else $error("local busy cut wrong");

	property p_lead_idle_cut;
		lead_fall && !rcv_fall |=> XMT_CUT && st.cut_tmr == `TIMER_W'(`CUT_HOLD_MS);
	endproperty
	a_lead_idle_cut: assert property (p_lead_idle_cut) else $error("local idle cut wrong");

	property p_pulse_cut;
		s_pulse_in_call |=> XMT_CUT ##1 XMT_CUT;
	endproperty
	a_pulse_cut: assert property (p_pulse_cut) else $error("dial pulse did not cut");

	property p_cut_tracks_timer;
		st.call == sf_sup_pkg::CALL_BUSY && st.cut_tmr != '0 |-> XMT_CUT;
	endproperty
	a_cut_tracks_timer: assert property (p_cut_tracks_timer) else $error("cut released early");

	property p_notch_arm;
		s_first_pulse |=> st.ins_tmr == `TIMER_W'(`NOTCH_INS_MS) &&
			st.hold_tmr == `TIMER_W'(`NOTCH_MIN_MS);
	endproperty
	a_notch_arm: assert property (p_notch_arm) else $error("notch insertion not armed");

	property p_notch_hold;
		st.hold_tmr > `TIMER_W'(1) && st.notch |=> RECEIVE_NOTCH_FILTER;
	endproperty
	a_notch_hold: assert property (p_notch_hold) else $error("notch removed before minimum");

	property p_notch_insert;
		st.ins_pend && st.ins_tmr == `TIMER_W'(1) && tick && !rcv_fall |=> RECEIVE_NOTCH_FILTER;
	endproperty
	a_notch_insert: assert property (p_notch_insert) else $error("notch not inserted");

	property p_idle_return;
		st.call == sf_sup_pkg::CALL_BUSY && !pins.sig_busy && pins.rcv_tone &&
			next_st.cut_tmr == '0 |=>
			st.call == sf_sup_pkg::CALL_IDLE && XMT_CUT && RECEIVE_NOTCH_FILTER;
	endproperty
	a_idle_return: assert property (p_idle_return) else $error("no return to idle");

	property p_manual;
		!st.ctrl.two_tone && !$past(st.ctrl.two_tone) |=>
			LOOPBACK == $past(pins.manual_loop_switch);
	endproperty
	a_manual: assert property (p_manual) else $error("manual loopback mismatch");

	property p_arm;
		st.ctrl.two_tone && st.loop == sf_sup_pkg::LOOP_OFF &&
			st.tone_cnt >= `TONE_W'(`ARM_TONE_MS) |=> st.loop == sf_sup_pkg::LOOP_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("two-tone arm missed");

	property p_disarm;
		st.ctrl.two_tone && st.loop_act &&
			st.tone_cnt >= `TONE_W'(`DISARM_TONE_MS) |=> !LOOPBACK;
	endproperty
	a_disarm: assert property (p_disarm) else $error("two-tone release missed");

	property p_tone_restart;
		!pins.loop_tone |=> st.tone_cnt == '0;
	endproperty
	a_tone_restart: assert property (p_tone_restart) else $error("tone counter kept");

	property p_busy_out;
		E_LEAD_GND |-> LOOPBACK && $past(st.ctrl.a_side) && $past(st.ctrl.type_one);
	endproperty
	a_busy_out: assert property (p_busy_out) else $error("E lead grounded wrongly");

	property p_lead_cut_fast;
		lead_rise || lead_fall |=> XMT_CUT;
	endproperty
	a_lead_cut_fast: assert property (p_lead_cut_fast) else $error("lead change not cut");

endmodule

`default_nettype wire

// *** pkg/sf_sup_pkg.sv ***
// types shared by the supervision and loopback block
`default_nettype none

package sf_sup_pkg;

	typedef enum logic [0:0] {CALL_IDLE, CALL_BUSY} call_t;

	typedef enum logic [1:0] {LOOP_OFF, LOOP_ARMED, LOOP_ON} loop_t;

	typedef enum logic [1:0] {TO_NONE, TO_SHORT, TO_LONG} timeout_t;

	// control register layout, bit 0 first from the right
	typedef struct packed {
		logic     type_one;
		logic     a_side;
		logic     busy_out;
		timeout_t timeout;
		logic     two_tone;
	} ctrl_t;

	// qualified pin levels after synchronising
	typedef struct packed {
		logic loop_tone;
		logic sig_busy;
		logic manual_loop_switch;
		logic rcv_tone;
	} pins_t;

	typedef struct packed {
		logic [2:0] ff;
		logic       q;
	} sync_t;

	typedef struct packed {
		logic [16:0] cnt;
		logic        tick;
	} tick_t;

endpackage

`default_nettype wire

// *** pkg/sf_sup_regs.svh ***
// offsets, widths, reset values and timing figures of the supervision block
`ifndef SF_SUP_REGS_SVH
`define SF_SUP_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_W          4
`define DATA_W          32
`define CTRL_OFS        4'h0
`define STATUS_OFS      4'h4
`define CTRL_W          6
`define CTRL_RESET      6'h00
`define STATUS_W        6

// ----------------------------------------
// timebase
// ----------------------------------------
`define CLK_MHZ         125
`define TICK_MS         1
`define TICK_CYCLES     (`TICK_MS * `CLK_MHZ * 1000)

// ----------------------------------------
// supervision intervals in ms
// ----------------------------------------
`define TIMER_W         10
`define CUT_HOLD_MS     625
`define NOTCH_REM_MS    50
`define LOCAL_CUT_MS    125
`define NOTCH_INS_MS    13
`define NOTCH_MIN_MS    225

// ----------------------------------------
// loopback intervals
// ----------------------------------------
`define TONE_W          11
`define ARM_TONE_MS     1400
`define DISARM_TONE_MS  700
`define LONG_W          21
`define TO_SHORT_DMIN   26
`define TO_LONG_DMIN    208
`define MS_PER_DMIN     6000

`endif

// *** verif/sf_far_end.sv ***
// far-end model: facility tones, local signaling lead and manual loop switch
`timescale 1ns/1ns
`default_nettype none

module sf_far_end #(
	parameter int TICK = 5
) (
	input  wire logic clk,
	output logic      rcv_tone,
	output logic      loop_tone,
	output logic      lead_busy,
	output logic      loop_switch
);
	// ----------------------------------------
	// line states, changed just after a clock edge
	// ----------------------------------------
	initial begin
		rcv_tone = 1'b1;
		loop_tone = 1'b0;
		lead_busy = 1'b0;
		loop_switch = 1'b0;
	end

	task automatic drive(input int sel, input logic v);
		@(posedge clk);
		case (sel)
			0: rcv_tone <= v;
			1: loop_tone <= v;
			2: lead_busy <= v;
			default: loop_switch <= v;
		endcase
	endtask

	task automatic hold_ms(input int n);
		repeat (n * TICK) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// *** verif/sf_supervision_loopback_ctrl_tb.sv ***
// self-checking bench for the supervision and loopback controller
`timescale 1ns/1ns
`default_nettype none

`include "sf_sup_regs.svh"

module sf_supervision_loopback_ctrl_tb;
	localparam int TK = 5;
	localparam int CUT = 0;
	localparam int NOTCH = 1;
	localparam int LOOP = 2;
	logic               SYS_CLK;
	logic               RST;
	logic               RCV_TONE;
	logic               LOOP_TONE;
	logic               SIG_LEAD_BUSY;
	logic               MANUAL_LOOP_SWITCH;
	logic [`ADDR_W-1:0] ADDR;
	logic [`DATA_W-1:0] WR_DATA;
	logic               WR_EN;
	logic               RD_EN;
	logic [`DATA_W-1:0] RD_DATA;
	logic               XMT_CUT;
	logic               RECEIVE_NOTCH_FILTER;
	logic               LOOPBACK;
	logic               E_LEAD_GND;
	logic [31:0]        rd;
	int                 n_mismatch;
	int                 n_compared;
	int                 t;

	sf_supervision_loopback_ctrl #(.TICK_CYCLES(TK), .TO_SHORT_MS(50), .TO_LONG_MS(100))
	sf_supervision_loopback_ctrl_inst (.SYS_CLK(SYS_CLK), .RST(RST), .RCV_TONE(RCV_TONE),
		.LOOP_TONE(LOOP_TONE), .SIG_LEAD_BUSY(SIG_LEAD_BUSY),
		.MANUAL_LOOP_SWITCH(MANUAL_LOOP_SWITCH), .ADDR(ADDR), .WR_DATA(WR_DATA),
		.WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .XMT_CUT(XMT_CUT),
		.RECEIVE_NOTCH_FILTER(RECEIVE_NOTCH_FILTER), .LOOPBACK(LOOPBACK),
		.E_LEAD_GND(E_LEAD_GND));

	sf_far_end #(.TICK(TK)) sf_far_end_inst (.clk(SYS_CLK), .rcv_tone(RCV_TONE),
		.loop_tone(LOOP_TONE), .lead_busy(SIG_LEAD_BUSY), .loop_switch(MANUAL_LOOP_SWITCH));

	// ----------------------------------------
	// helpers and compares
	// ----------------------------------------
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic miss(input logic [31:0] g, input logic [31:0] e);
		n_mismatch++;
		$display("mismatch at %0t: got %0h expected %0h", $time, g, e);
	endtask

	task automatic check_word(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) miss(g, e);
	endtask

	task automatic check_bit(input logic g, input logic e);
		check_word({31'h00000000, g}, {31'h00000000, e});
	endtask

	task automatic check_range(input int g, input int lo, input int hi);
		n_compared++;
		if (g < lo || g > hi) begin
			n_mismatch++;
			$display("mismatch at %0t: got %0h expected %0h..%0h", $time, g, lo, hi);
		end
	endtask

	function automatic logic cur(input int sel);
		if (sel == CUT) return XMT_CUT;
		if (sel == NOTCH) return RECEIVE_NOTCH_FILTER;
		return LOOPBACK;
	endfunction

	// waits for an output level, t counts cycles since the last pin change
	task automatic expect_at(input int sel, input logic v, input int lo, input int hi);
		while (cur(sel) !== v) begin
			@(posedge SYS_CLK);
			#1;
			t++;
			if (t > (hi + 20) * TK) begin
				miss({31'h00000000, cur(sel)}, {31'h00000000, v});
				results();
			end
		end
		check_range(t, lo * TK, hi * TK);
	endtask

	task automatic pin(input int sel, input logic v);
		sf_far_end_inst.drive(sel, v);
		t = 0;
	endtask

	task automatic ms(input int n);
		sf_far_end_inst.hold_ms(n);
		#1;
	endtask

	task automatic reg_wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WR_DATA <= d;
		WR_EN <= 1'b1;
		@(posedge SYS_CLK);
		WR_EN <= 1'b0;
	endtask

	task automatic reg_rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD_EN <= 1'b1;
		@(posedge SYS_CLK);
		RD_EN <= 1'b0;
		#1;
		d = RD_DATA;
	endtask

	task automatic status_is(input logic [31:0] e);
		reg_rd(`STATUS_OFS, rd);
		check_word(rd, e);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		ms(10);
		check_bit(XMT_CUT, 1'b1);
		check_bit(RECEIVE_NOTCH_FILTER, 1'b1);
		check_bit(LOOPBACK, 1'b0);
		check_bit(E_LEAD_GND, 1'b0);
		status_is(32'h00000003);
		reg_wr(4'h8, 32'h0000003F);
		reg_rd(4'h8, rd);
		check_word(rd, 32'h00000000);
		reg_rd(`CTRL_OFS, rd);
		check_word(rd, 32'h00000000);
		@(posedge SYS_CLK);
		#1;
		check_word(RD_DATA, 32'h00000000);
	endtask

	task automatic t_seizure();
		pin(0, 1'b0);
		expect_at(NOTCH, 1'b0, 45, 55);
		expect_at(CUT, 1'b0, 500, 750);
		status_is(32'h00000010);
	endtask

	task automatic t_dial(input int n, input int lo, input int hi);
		pin(0, 1'b1);
		expect_at(CUT, 1'b1, 0, 7);
		expect_at(NOTCH, 1'b1, 6, 20);
		ms(40);
		repeat (n - 1) begin
			pin(0, 1'b0);
			ms(40);
			pin(0, 1'b1);
			ms(60);
		end
		check_bit(XMT_CUT, 1'b1);
		pin(0, 1'b0);
		expect_at(NOTCH, 1'b0, lo, hi);
		expect_at(CUT, 1'b0, 500, 750);
	endtask

	task automatic t_lead(input logic v, input int lo, input int hi);
		pin(2, v);
		expect_at(CUT, 1'b1, 0, 5);
		expect_at(CUT, 1'b0, lo, hi);
	endtask

	task automatic t_disconnect();
		pin(0, 1'b1);
		expect_at(NOTCH, 1'b1, 6, 20);
		ms(700);
		pin(2, 1'b0);
		expect_at(CUT, 1'b1, 0, 5);
		ms(900);
		check_bit(XMT_CUT, 1'b1);
		status_is(32'h00000003);
	endtask

	task automatic t_manual();
		reg_wr(`CTRL_OFS, 32'h00000038);
		pin(3, 1'b1);
		expect_at(LOOP, 1'b1, 0, 2);
		ms(1);
		check_bit(E_LEAD_GND, 1'b1);
		status_is(32'h00000027);
		reg_wr(`CTRL_OFS, 32'h00000018);
		ms(1);
		check_bit(E_LEAD_GND, 1'b0);
		reg_wr(`CTRL_OFS, 32'h00000028);
		ms(1);
		check_bit(E_LEAD_GND, 1'b0);
		pin(3, 1'b0);
		expect_at(LOOP, 1'b0, 0, 2);
		pin(1, 1'b1);
		ms(1420);
		pin(1, 1'b0);
		ms(5);
		check_bit(LOOPBACK, 1'b0);
		status_is(32'h00000003);
	endtask

	task automatic t_restart();
		reg_wr(`CTRL_OFS, 32'h00000001);
		pin(1, 1'b1);
		ms(1000);
		pin(1, 1'b0);
		ms(20);
		pin(1, 1'b1);
		ms(500);
		status_is(32'h00000003);
		pin(1, 1'b0);
		ms(5);
		check_bit(LOOPBACK, 1'b0);
	endtask

	task automatic arm(input int code);
		reg_wr(`CTRL_OFS, 32'(code * 2 + 1));
		pin(1, 1'b1);
		ms(1420);
		status_is(32'h0000000B);
		check_bit(LOOPBACK, 1'b0);
		pin(1, 1'b0);
		expect_at(LOOP, 1'b1, 0, 2);
	endtask

	task automatic t_release(input int code);
		arm(code);
		ms(150);
		check_bit(LOOPBACK, 1'b1);
		pin(1, 1'b1);
		expect_at(LOOP, 1'b0, 695, 720);
		pin(1, 1'b0);
		ms(10);
	endtask

	task automatic t_timeout(input int code, input int len);
		arm(code);
		t = 0;
		expect_at(LOOP, 1'b0, len - 2, len + 2);
	endtask

	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end

	initial begin
		RST = 1'b1;
		ADDR = '0;
		WR_DATA = '0;
		WR_EN = 1'b0;
		RD_EN = 1'b0;
		n_mismatch = 0;
		n_compared = 0;
		t = 0;
		repeat (20) @(posedge SYS_CLK);
		RST <= 1'b0;
		t_reset();
		t_seizure();
		t_dial(1, 120, 222);
		t_dial(3, 45, 55);
		t_lead(1'b1, 75, 175);
		t_lead(1'b0, 500, 750);
		t_lead(1'b1, 75, 175);
		t_disconnect();
		t_manual();
		t_restart();
		t_release(0);
		t_release(3);
		t_timeout(1, 50);
		t_timeout(2, 100);
		results();
	end
endmodule

`default_nettype wire
